//--- inc/motion_wake_params.svh
// constants for the motion-wake detector: register indices, field positions,
// reset values. assumes a 32-bit classic wishbone bus, one register per word.
`ifndef MOTION_WAKE_PARAMS_SVH
`define MOTION_WAKE_PARAMS_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define IDX_SHADOW_WINDOW 6'h13
`define IDX_MOTION_CFG    6'h14
`define IDX_DETECT_CTRL   6'h20
`define IDX_DETECT_STATUS 6'h21

// ==========================================================================
// motion_detect_config fields
`define CFG_SEL_LSB   0
`define CFG_CNTEN_BIT 3
`define CFG_MUX_LSB   4
`define CFG_RESET_BIT 7
`define CFG_RESET_VAL 8'h00

// ==========================================================================
// detect_ctrl fields
`define CTRL_COMBINE_BIT  0
`define CTRL_DELTA_REF_BIT 1
`define CTRL_AXIS_EN_LSB  4
`define CTRL_RESET_VAL    8'h70

// ==========================================================================
// detect_status fields
`define STAT_WAKE_BIT   0
`define STAT_MET_LSB    4

// ==========================================================================
// datapath sizes
`define DELTA_W   11
`define SLICE_W   6
`define DELTA_MAX 11'h7FF

`endif

//--- inc/motion_wake_pkg.sv
// types shared by the motion-wake detector modules.
// assumes motion_wake_params.svh supplies the widths.
`include "motion_wake_params.svh"

package motion_wake_pkg;

  typedef logic [31:0]              wb_word_t;
  typedef logic [`DELTA_W-1:0]      delta_t;
  typedef logic [`SLICE_W-1:0]      slice_t;
  typedef logic [2:0]               mux_sel_t;

  // target of a shadow-window access
  typedef enum logic [2:0] {
    sh_none,
    sh_thr,
    sh_cnt
  } shadow_kind_t;

endpackage : motion_wake_pkg

//--- inc/axis_cmp_if.sv
// carries one axis delta, slice select and threshold to the comparator.
// assumes both ends run on core_clk; the comparator itself is combinational.
`timescale 1ns/10ps

interface axis_cmp_if;
  import motion_wake_pkg::*;
  delta_t   delta;
  mux_sel_t slice_sel;
  slice_t   threshold;
  logic     hit;

  modport src (output delta, output slice_sel, output threshold, input hit);
  modport cmp (input delta, input slice_sel, input threshold, output hit);
endinterface : axis_cmp_if

//--- rtl/axis_compare.sv
// slice-select, clamp and threshold compare for one axis.
// assumes delta is already an absolute value; purely combinational.
`timescale 1ns/10ps

module axis_compare (
  axis_cmp_if.cmp port_i
);
  import motion_wake_pkg::*;

  // ========================================================================
  // clamp
  // saturating instead of truncating keeps large motion visible
  function automatic slice_t clamp_slice(input delta_t d, input mux_sel_t sel);
    delta_t shifted;
    logic [2:0] n;
    n = (sel > 3'd5) ? 3'd5 : sel;
    shifted = d >> n;
    if (shifted > delta_t'(6'h3F)) begin
      clamp_slice = 6'h3F;
    end else begin
      clamp_slice = shifted[`SLICE_W-1:0];
    end
  endfunction : clamp_slice

  always_comb begin
    port_i.hit = clamp_slice(port_i.delta, port_i.slice_sel) >= port_i.threshold;
  end

endmodule : axis_compare

//--- rtl/motion_wake_detector_config.sv
// motion-wake detector configuration, shadow window and per-axis comparison.
// assumes samples arrive on core_clk with a one-cycle sample_valid strobe.
`timescale 1ns/10ps
`include "motion_wake_params.svh"

module motion_wake_detector_config #(
  parameter int ADDR_W   = 8,
  parameter int SAMPLE_W = 12
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ADDR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire motion_wake_pkg::wb_word_t wb_dat_i,
  output      motion_wake_pkg::wb_word_t wb_dat_o,
  output      logic                      wb_ack_o,
  input  wire logic                      sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] sample_x,
  input  wire logic signed [SAMPLE_W-1:0] sample_y,
  input  wire logic signed [SAMPLE_W-1:0] sample_z,
  output      logic                      motion_wake
);
  import motion_wake_pkg::*;

  // ========================================================================
  // elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 8 to 32");
  end
  if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_sample
    $error("SAMPLE_W must be 2 to 16");
  end

  // ========================================================================
  // decode
  function automatic shadow_kind_t shadow_kind(input logic [2:0] s);
    if (s[1:0] == 2'b00) begin
      shadow_kind = sh_none;
    end else if (s[2]) begin
      shadow_kind = sh_cnt;
    end else begin
      shadow_kind = sh_thr;
    end
  endfunction : shadow_kind

  // ========================================================================
  // state
  logic [7:0]                 motion_detect_config, next_config;
  logic [7:0]                 detect_ctrl, next_ctrl;
  logic [5:0]                 threshold [3], next_threshold [3];
  logic [5:0]                 det_count [3], next_det_count [3];
  logic [5:0]                 ev_count [3], next_ev_count [3];
  logic signed [SAMPLE_W-1:0] ref_sample [3], next_ref_sample [3];
  logic                       have_ref, next_have_ref;
  logic                       det_reset, next_det_reset;
  logic                       next_wake;
  logic                       next_ack;
  wb_word_t                   next_dat;
  logic                       hit [3];
  delta_t                     delta [3];
  logic [2:0]                 met;
  logic signed [SAMPLE_W-1:0] cur [3];

  assign cur[0] = sample_x;
  assign cur[1] = sample_y;
  assign cur[2] = sample_z;

  wire [2:0]  sel        = motion_detect_config[`CFG_SEL_LSB +: 3];
  wire        cnt_en     = motion_detect_config[`CFG_CNTEN_BIT];
  wire [2:0]  mux        = motion_detect_config[`CFG_MUX_LSB +: 3];
  wire        combine    = detect_ctrl[`CTRL_COMBINE_BIT];
  wire        delta_ref  = detect_ctrl[`CTRL_DELTA_REF_BIT];
  wire [2:0]  axis_en    = detect_ctrl[`CTRL_AXIS_EN_LSB +: 3];
  wire [5:0]  word_idx   = wb_adr_i[7:2];
  wire        req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr_lane0   = req && wb_we_i && wb_sel_i[0];
  wire [1:0]  sel_axis   = sel[1:0] - 2'd1;

  // ========================================================================
  // per-axis delta and comparator
  for (genvar a = 0; a < 3; a++) begin : g_axis
    axis_cmp_if link ();
    logic signed [SAMPLE_W:0] diff;
    logic [SAMPLE_W:0]        mag;
    always_comb begin
      diff = (SAMPLE_W+1)'(cur[a]) - (SAMPLE_W+1)'(ref_sample[a]);
      mag  = diff[SAMPLE_W] ? (SAMPLE_W+1)'(-diff) : diff;
      // 11-bit delta saturates so wide samples never wrap
      if (mag > (SAMPLE_W+1)'(`DELTA_MAX)) begin
        delta[a] = `DELTA_MAX;
      end else begin
        delta[a] = `DELTA_W'(mag);
      end
    end
    assign link.delta     = delta[a];
    assign link.slice_sel = mux;
    assign link.threshold = threshold[a];
    assign hit[a]         = link.hit;
    axis_compare u_cmp (.port_i(link.cmp));
  end

  // ========================================================================
  // registers and shadow window
  always_comb begin
    next_config    = motion_detect_config;
    next_ctrl      = detect_ctrl;
    next_threshold = threshold;
    next_det_count = det_count;
    next_det_reset = 1'b0;
    next_ack       = req;
    next_dat       = '0;
    if (wr_lane0) begin
      unique case (word_idx)
        `IDX_MOTION_CFG: begin
          next_config    = {1'b0, wb_dat_i[6:0]};
          next_det_reset = wb_dat_i[`CFG_RESET_BIT];
        end
        `IDX_DETECT_CTRL: begin
          next_ctrl = {1'b0, wb_dat_i[6:4], 2'b00, wb_dat_i[1:0]};
        end
        `IDX_SHADOW_WINDOW: begin
          unique case (shadow_kind(sel))
            sh_thr:  next_threshold[sel_axis] = wb_dat_i[5:0];
            sh_cnt:  next_det_count[sel_axis] = wb_dat_i[5:0];
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (word_idx)
        `IDX_MOTION_CFG:    next_dat = {24'h000000, motion_detect_config};
        `IDX_DETECT_CTRL:   next_dat = {24'h000000, detect_ctrl};
        `IDX_DETECT_STATUS: next_dat = {25'h0000000, met, 3'b000, motion_wake};
        `IDX_SHADOW_WINDOW: begin
          unique case (shadow_kind(sel))
            sh_thr:  next_dat = {26'h0000000, threshold[sel_axis]};
            sh_cnt:  next_dat = {26'h0000000, det_count[sel_axis]};
            default: next_dat = '0;
          endcase
        end
        default: next_dat = '0;
      endcase
    end
  end

  // ========================================================================
  // detection
  always_comb begin
    next_ev_count   = ev_count;
    next_ref_sample = ref_sample;
    next_have_ref   = have_ref;
    for (int a = 0; a < 3; a++) begin
      // count reaching det_count+1 events means the axis qualifies
      met[a] = cnt_en && ({1'b0, ev_count[a]} > {1'b0, det_count[a]});
    end
    if (sample_valid) begin
      next_have_ref = 1'b1;
      for (int a = 0; a < 3; a++) begin
        if (!have_ref || !delta_ref) begin
          next_ref_sample[a] = cur[a];
        end
        if (have_ref && axis_en[a] && cnt_en && hit[a] && ev_count[a] != 6'h3F) begin
          next_ev_count[a] = ev_count[a] + 6'd1;
        end
      end
    end
    if (det_reset) begin
      next_have_ref = 1'b0;
      for (int a = 0; a < 3; a++) begin
        next_ev_count[a] = '0;
      end
    end
    // powered-down axes drop out of both AND and OR
    if (combine) begin
      next_wake = cnt_en && (axis_en != 3'b000) && ((met | ~axis_en) == 3'b111);
    end else begin
      next_wake = cnt_en && ((met & axis_en) != 3'b000);
    end
    // re-arm clears wake outright: met still shows the counters being cleared,
    // and a sample landing with the pulse is dropped by the counter clear anyway
    next_wake = !det_reset && (next_wake || motion_wake);
  end

  // ========================================================================
  // flip-flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      motion_detect_config <= `CFG_RESET_VAL;
      detect_ctrl          <= `CTRL_RESET_VAL;
      threshold            <= '{default: '0};
      det_count            <= '{default: '0};
      ev_count             <= '{default: '0};
      ref_sample           <= '{default: '0};
      have_ref             <= 1'b0;
      det_reset            <= 1'b0;
      motion_wake          <= 1'b0;
      wb_ack_o             <= 1'b0;
      wb_dat_o             <= '0;
    end else if (ce) begin
      motion_detect_config <= next_config;
      detect_ctrl          <= next_ctrl;
      threshold            <= next_threshold;
      det_count            <= next_det_count;
      ev_count             <= next_ev_count;
      ref_sample           <= next_ref_sample;
      have_ref             <= next_have_ref;
      det_reset            <= next_det_reset;
      motion_wake          <= next_wake;
      wb_ack_o             <= next_ack;
      wb_dat_o             <= next_dat;
    end
  end

endmodule : motion_wake_detector_config

//--- bench/motion_wake_props.sv
// port checker for the motion-wake detector.
// assumes ce is held high and ADDR_W is 8; bound to the design top below.
`timescale 1ns/10ps

module motion_wake_props #(
  parameter int ADDR_W = 8
) (
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire logic                      ce,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [ADDR_W-1:0]         wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire motion_wake_pkg::wb_word_t wb_dat_i,
  input wire motion_wake_pkg::wb_word_t wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      sample_valid,
  input wire logic                      motion_wake
);
  import motion_wake_pkg::*;
  // ==========================================================================
  // helpers
  logic       take;
  logic       cfg_wr;
  logic       drst_take;
  logic       cnt_en;
  logic       next_cnt_en;
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign cfg_wr = take && wb_we_i && wb_sel_i[0] && idx == 6'h14;
  assign drst_take = cfg_wr && wb_dat_i[7];
  // shadow of count enable, so a wakeup can be tied to its cause
  always_comb begin
    next_cnt_en = cnt_en;
    if (rst)
      next_cnt_en = 1'b0;
    else if (cfg_wr)
      next_cnt_en = wb_dat_i[3];
  end
  always_ff @(posedge core_clk) begin
    cnt_en <= next_cnt_en;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // assertions
  ack_answer_a: assert property (take |=> wb_ack_o) else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  write_data_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == '0) else $error("write ack data");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !(idx inside {6'h13, 6'h14, 6'h20, 6'h21})
    |-> wb_dat_o == '0) else $error("unmapped read not zero");
  cfg_selfclear_a: assert property (wb_ack_o && !wb_we_i && idx == 6'h14 |-> wb_dat_o[31:7] == '0)
    else $error("reset bit reads back set");
  status_wake_a: assert property (wb_ack_o && !wb_we_i && idx == 6'h21
    |-> wb_dat_o[0] == $past(motion_wake)) else $error("status wake bit stale");
  // the wake edge was decided one cycle earlier, with the count enable of that cycle
  wake_needs_count_a: assert property ($rose(motion_wake) |-> $past(cnt_en))
    else $error("wake without count");
  wake_latency_a: assert property ($rose(motion_wake) |-> $past(sample_valid, 2))
    else $error("wake not two edges after sample");
  det_reset_a: assert property (drst_take && !sample_valid ##1 !sample_valid |=> !motion_wake)
    else $error("detector reset left wake set");
  wake_sticky_a: assert property ($fell(motion_wake) |-> $past(rst) || $past(drst_take, 2))
    else $error("wake dropped without reset");
endmodule : motion_wake_props

bind motion_wake_detector_config motion_wake_props #(.ADDR_W(ADDR_W)) i_props (
  .core_clk(core_clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_valid(sample_valid), .motion_wake(motion_wake));

//--- bench/host_model.sv
// host microcontroller model issuing classic wishbone single cycles.
// assumes a slave that acks every request; the bench watchdog ends a hang.
`timescale 1ns/10ps

module host_model (
  input  wire logic                      core_clk,
  input  wire motion_wake_pkg::wb_word_t wb_dat_o,
  input  wire logic                      wb_ack_o,
  output      logic                      wb_cyc_i,
  output      logic                      wb_stb_i,
  output      logic                      wb_we_i,
  output      logic [7:0]                wb_adr_i,
  output      logic [3:0]                wb_sel_i,
  output      motion_wake_pkg::wb_word_t wb_dat_i
);
  import motion_wake_pkg::*;
  // ==========================================================================
  // bus cycle
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // the leading edge guarantees an idle cycle between requests
  task automatic access(input logic we, input logic [5:0] idx, input wb_word_t wdat, output wb_word_t rdat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'hF;
    wb_dat_i <= wdat;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    wb_dat_i <= ~wdat;
  endtask : access
endmodule : host_model

//--- bench/tb_top.sv
// self-checking bench: register window, slice and clamp compare, detector reset.
// assumes the host model drives the bus; samples of all three axes are driven here.
`timescale 1ns/10ps

module tb_top;
  import motion_wake_pkg::*;
  typedef struct packed {
    logic [2:0] mux; logic [5:0] thr; logic [10:0] d; logic en; logic [5:0] cnt; logic [7:0] ctrl; logic exp;
  } case_t;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               sample_valid = 1'b0;
  logic signed [11:0] sample_x = 12'h000;
  logic signed [11:0] sample_y = 12'h000;
  logic signed [11:0] sample_z = 12'h000;
  logic               motion_wake;
  logic               wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  wb_word_t           wb_dat_i, wb_dat_o, rd;
  int                 mismatches = 0;
  int                 n_tests = 0;
  case_t cases [16] = '{
    '{3'h0, 6'h05, 11'h005, 1'h1, 6'h00, 8'h70, 1'h1}, '{3'h0, 6'h06, 11'h005, 1'h1, 6'h00, 8'h70, 1'h0},
    '{3'h2, 6'h03, 11'h00C, 1'h1, 6'h00, 8'h70, 1'h1}, '{3'h2, 6'h04, 11'h00F, 1'h1, 6'h00, 8'h70, 1'h0},
    '{3'h0, 6'h01, 11'h040, 1'h1, 6'h00, 8'h70, 1'h1}, '{3'h7, 6'h20, 11'h400, 1'h1, 6'h00, 8'h70, 1'h1},
    '{3'h6, 6'h21, 11'h400, 1'h1, 6'h00, 8'h70, 1'h0}, '{3'h5, 6'h3F, 11'h7F8, 1'h1, 6'h00, 8'h70, 1'h1},
    '{3'h4, 6'h02, 11'h020, 1'h1, 6'h00, 8'h70, 1'h1}, '{3'h1, 6'h10, 11'h020, 1'h1, 6'h00, 8'h70, 1'h1},
    '{3'h3, 6'h08, 11'h03F, 1'h1, 6'h00, 8'h70, 1'h0}, '{3'h0, 6'h05, 11'h005, 1'h0, 6'h00, 8'h70, 1'h0},
    '{3'h0, 6'h05, 11'h005, 1'h1, 6'h01, 8'h70, 1'h0}, '{3'h0, 6'h05, 11'h005, 1'h1, 6'h01, 8'h72, 1'h1},
    '{3'h0, 6'h05, 11'h005, 1'h1, 6'h00, 8'h71, 1'h0}, '{3'h0, 6'h05, 11'h005, 1'h1, 6'h00, 8'h11, 1'h1}};
  always #2 core_clk = ~core_clk;
  host_model i_host (.core_clk(core_clk), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
  motion_wake_detector_config i_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .motion_wake(motion_wake));
  // ==========================================================================
  // tasks
  task automatic check(input wb_word_t seen, input wb_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    i_host.access(1'b1, idx, {24'h0, d}, rd);
  endtask : wr
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
    i_host.access(1'b0, idx, 32'h0, rd);
    check(rd, {24'h0, e});
  endtask : rd_chk
  task automatic send(input logic signed [11:0] x, input logic signed [11:0] y, input logic signed [11:0] z);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    sample_x <= ~x;
    sample_y <= ~y;
    sample_z <= ~z;
  endtask : send
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // tests
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(6'h14, 8'h00);
    rd_chk(6'h20, 8'h70);
    rd_chk(6'h21, 8'h00);
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h14, 8'(c));
      wr(6'h13, 8'(8'h20 + c));
    end
    for (int c = 0; c < 8; c++) begin
      wr(6'h14, 8'(c));
      rd_chk(6'h13, (c % 4 == 0) ? 8'h00 : 8'(8'h20 + c));
    end
    rd_chk(6'h3F, 8'h00);
    wr(6'h14, 8'h8B);
    rd_chk(6'h14, 8'h0B);
    $display("test shadow window done");
    // re-arm first, so that old counts cannot raise a wake while the setup is rewritten
    foreach (cases[i]) begin
      wr(6'h14, {1'b1, cases[i].mux, cases[i].en, 3'h0});
      wr(6'h20, cases[i].ctrl);
      wr(6'h14, {1'b0, cases[i].mux, cases[i].en, 3'h1});
      wr(6'h13, {2'h0, cases[i].thr});
      wr(6'h14, {1'b0, cases[i].mux, cases[i].en, 3'h5});
      wr(6'h13, {2'h0, cases[i].cnt});
      send(12'h000, 12'h000, 12'h000);
      send(12'(cases[i].d), 12'h000, 12'h000);
      send(12'(cases[i].d), 12'h000, 12'h000);
      repeat (4) @(posedge core_clk);
      check({31'h0, motion_wake}, {31'h0, cases[i].exp});
    end
    rd_chk(6'h21, 8'h11);
    $display("test compare cases done");
    wr(6'h14, 8'h8E);
    wr(6'h13, 8'h00);
    wr(6'h14, 8'h0F);
    wr(6'h13, 8'h00);
    wr(6'h20, 8'h71);
    send(12'h000, 12'h000, 12'h000);
    send(12'h005, 12'hFDE, 12'h022);
    repeat (4) @(posedge core_clk);
    check({31'h0, motion_wake}, 32'h0);
    send(12'h000, 12'h000, 12'hFFF);
    repeat (4) @(posedge core_clk);
    check({31'h0, motion_wake}, 32'h1);
    rd_chk(6'h21, 8'h71);
    $display("test combine all axes done");
    wr(6'h14, 8'h80);
    repeat (2) @(posedge core_clk);
    check({31'h0, motion_wake}, 32'h0);
    rd_chk(6'h21, 8'h00);
    $display("test detector reset done");
    report_and_stop();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
endmodule : tb_top
